// [logic/rtu_pkg.sv]
// Constants, codes and the frame check function of the register slave.
package rtu_pkg;

	localparam int CLK_HZ     = 20_000_000;
	localparam int BAUD_4800  = 4800;
	localparam int BAUD_9600  = 9600;
	localparam int BAUD_19200 = 19200;

	localparam logic [1:0] BAUD_SEL_4800  = 2'h0;
	localparam logic [1:0] BAUD_SEL_9600  = 2'h1;
	localparam logic [1:0] BAUD_SEL_19200 = 2'h2;
	localparam logic [1:0] PARITY_NONE    = 2'h0;
	localparam logic [1:0] PARITY_ODD     = 2'h1;
	localparam logic [1:0] PARITY_EVEN    = 2'h2;

	localparam logic [3:0] CHAR_BITS_BASE       = 4'hA;
	localparam int         GAP_END_HALF_CHARS   = 7;
	localparam int         GAP_BREAK_HALF_CHARS = 3;

	localparam int FRAME_DEPTH = 32;
	localparam int FRAME_AW    = 5;
	localparam int PARAM_DEPTH = 16;
	localparam int PARAM_AW    = 4;

	localparam logic [7:0] FN_READ       = 8'h03;
	localparam logic [7:0] FN_WRITE_ONE  = 8'h06;
	localparam logic [7:0] FN_WRITE_MANY = 8'h10;
	localparam logic [7:0] EXC_FLAG      = 8'h80;
	localparam logic [7:0] EXC_FUNCTION  = 8'h01;
	localparam logic [7:0] EXC_ADDRESS   = 8'h02;
	localparam logic [7:0] EXC_VALUE     = 8'h03;

	localparam logic [15:0] REG_BASE            = 16'h2000;
	localparam logic [15:0] REG_DECIMAL_POINT   = 16'h2002;
	localparam logic [15:0] REG_TEMP_SETPOINT   = 16'h2003;
	localparam logic [15:0] REG_COUNT           = 16'h0009;
	localparam logic [15:0] REG_FIRST_WRITABLE  = 16'h0002;
	localparam logic [15:0] PARAM_RESET         = 16'h0000;
	localparam logic [15:0] LIMIT_DECIMAL_POINT = 16'h0001;
	localparam logic [15:0] LIMIT_DEFAULT       = 16'h03E8;

	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;

	localparam logic [5:0] POS_FUNCTION     = 6'h01;
	localparam logic [5:0] POS_START_HI     = 6'h02;
	localparam logic [5:0] POS_START_LO     = 6'h03;
	localparam logic [5:0] POS_QTY_HI       = 6'h04;
	localparam logic [5:0] POS_QTY_LO       = 6'h05;
	localparam logic [5:0] POS_BYTE_COUNT   = 6'h06;
	localparam logic [5:0] POS_DATA_SINGLE  = 6'h04;
	localparam logic [5:0] POS_DATA_MULTI   = 6'h07;
	localparam logic [5:0] MIN_FRAME_LEN    = 6'h04;
	localparam logic [5:0] FIXED_FRAME_LEN  = 6'h08;
	localparam logic [7:0] MULTI_OVERHEAD   = 8'h09;
	localparam logic [5:0] EXC_REPLY_LEN    = 6'h05;
	localparam logic [5:0] WRITE_REPLY_LEN  = 6'h08;
	localparam logic [5:0] READ_REPLY_EXTRA = 6'h05;

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

endpackage

// [logic/rtu_mem_if.sv]
// Port bundle between the slave and its memories.
`timescale 1ns/1ps
`default_nettype none
interface rtu_mem_if #(
	parameter int WIDTH = 8,
	parameter int AW    = 5
);
	logic             we;
	logic [AW-1:0]    waddr;
	logic [WIDTH-1:0] wdata;
	logic [AW-1:0]    raddr;
	logic [WIDTH-1:0] rdata;

	modport user  (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [logic/rtu_ram.sv]
// Small memory with one write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none
module rtu_ram #(
	parameter int               WIDTH       = 8,
	parameter int               AW          = 5,
	parameter int               DEPTH       = 32,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic  clk,
	input wire logic  arst_n,
	rtu_mem_if.store  port
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= RESET_VALUE;
			end
			port.rdata <= '0;
		end else begin
			if (port.we) begin
				mem[port.waddr] <= port.wdata;
			end
			port.rdata <= mem[port.raddr];
		end
	end
endmodule
`default_nettype wire

// [logic/rtu_register_slave.sv]
// Half-duplex serial request interpreter serving 16-bit parameter registers.
// Behaviour
// - Accept read 0x03, writes 0x06 and 0x10.
// - Reply only after request; release driver afterwards.
// - Frames end with CRC, low byte first.
// - Bad CRC frames dropped without any reply.
// - Characters: start, eight data, optional parity, stop.
// - Exception replies set function code top bit.
// - Unsupported function answered with code 0x01.
// - Address outside implemented range gives 0x02.
// - Out-of-range value gives 0x03, nothing written.
// - Exception reply: station, function, code, CRC.
// - Read reply: count bytes, values high first.
// - Each parameter is one 16-bit integer register.
// - Temperature setpoint lives at register 0x2003.
// - Baud selection 0, 1, 2 maps 4800/9600/19200.
// - Parity selection 0 none, 1 odd, 2 even.
// - Single write reply echoes the request exactly.
// - Multi write reply: start, count, fresh CRC.
`timescale 1ns/1ps
`default_nettype none
module rtu_register_slave #(
	parameter int BIT_CYCLES_4800  = rtu_pkg::CLK_HZ / rtu_pkg::BAUD_4800,
	parameter int BIT_CYCLES_9600  = rtu_pkg::CLK_HZ / rtu_pkg::BAUD_9600,
	parameter int BIT_CYCLES_19200 = rtu_pkg::CLK_HZ / rtu_pkg::BAUD_19200
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        rx_line,
	output logic             tx_line,
	output logic             tx_enable,
	input  wire logic [7:0]  station_address,
	input  wire logic [1:0]  baud_select,
	input  wire logic [1:0]  parity_select,
	input  wire logic [15:0] temp_measured,
	input  wire logic [15:0] humi_measured,
	output logic [15:0]      temperature_setpoint
);
	typedef enum logic [2:0] {
		C_IDLE, C_FETCH, C_DECIDE, C_SWEEP, C_REWIND, C_RESP_LOAD, C_RESP_SEND, C_RESP_WAIT
	} ctl_t;

	function automatic logic parity_bit(input logic [7:0] data, input logic [1:0] sel);
		return (sel == rtu_pkg::PARITY_ODD) ? ~^data : ^data;
	endfunction

	// ---------------------------------------------------------------
	// Line timing.
	// ---------------------------------------------------------------
	logic [12:0] bit_cycles;
	logic        par_en;
	logic [3:0]  char_bits;
	logic [19:0] char_cycles;
	logic [19:0] gap_end;
	logic [19:0] gap_break;

	assign bit_cycles  = (baud_select == rtu_pkg::BAUD_SEL_4800)  ? 13'(BIT_CYCLES_4800) :
	                     (baud_select == rtu_pkg::BAUD_SEL_19200) ? 13'(BIT_CYCLES_19200) :
	                     13'(BIT_CYCLES_9600);
	assign par_en      = (parity_select == rtu_pkg::PARITY_ODD) ||
	                     (parity_select == rtu_pkg::PARITY_EVEN);
	assign char_bits   = rtu_pkg::CHAR_BITS_BASE + {3'h0, par_en};
	assign char_cycles = 20'(bit_cycles) * 20'(char_bits);
	assign gap_end     = (char_cycles * 20'(rtu_pkg::GAP_END_HALF_CHARS)) >> 1;
	assign gap_break   = (char_cycles * 20'(rtu_pkg::GAP_BREAK_HALF_CHARS)) >> 1;

	// ---------------------------------------------------------------
	// Receiver.
	// ---------------------------------------------------------------
	logic        rx_s1;
	logic        rx_s2;
	logic        rx_busy;
	logic [12:0] rx_cnt;
	logic [3:0]  rx_bit;
	logic [7:0]  rx_data;
	logic        rx_par;
	logic        rx_done;
	logic        rx_err;
	logic        rx_start;
	logic [3:0]  rx_last;

	assign rx_start = !rx_busy && !rx_s2;
	assign rx_last  = 4'h9 + {3'h0, par_en};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end else begin
			rx_s1 <= rx_line;
			rx_s2 <= rx_s1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_busy <= 1'b0;
			rx_cnt  <= 13'h0000;
			rx_bit  <= 4'h0;
			rx_data <= 8'h00;
			rx_par  <= 1'b0;
			rx_done <= 1'b0;
			rx_err  <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (rx_start) begin
				rx_busy <= 1'b1;
				rx_cnt  <= bit_cycles >> 1;
				rx_bit  <= 4'h0;
			end else if (rx_busy && rx_cnt != 13'h0000) begin
				rx_cnt <= rx_cnt - 13'h0001;
			end else if (rx_busy) begin
				rx_cnt <= bit_cycles - 13'h0001;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0 && rx_s2) begin
					rx_busy <= 1'b0;
				end else if (rx_bit == rx_last) begin
					rx_busy <= 1'b0;
					rx_done <= 1'b1;
					rx_err  <= !rx_s2 || (par_en && rx_par != parity_bit(rx_data, parity_select));
				end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
					rx_data[3'(rx_bit - 4'h1)] <= rx_s2;
				end else if (rx_bit == 4'h9) begin
					rx_par <= rx_s2;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Frame assembly.
	// ---------------------------------------------------------------
	ctl_t        ctl;
	logic [19:0] gap_cnt;
	logic [5:0]  frame_len;
	logic        frame_bad;
	logic [15:0] frame_crc;
	logic [7:0]  frame_station;
	logic        frame_end;
	logic        frame_accept;
	logic        ctl_idle;

	rtu_mem_if #(.WIDTH(8), .AW(rtu_pkg::FRAME_AW)) frame_bus ();
	rtu_mem_if #(.WIDTH(16), .AW(rtu_pkg::PARAM_AW)) param_bus ();

	assign ctl_idle  = (ctl == C_IDLE);
	// end of frame on long gap
	assign frame_end = ctl_idle && !rx_busy && frame_len != 6'h00 && gap_cnt == gap_end - 20'h1;
	// only good frames for this station
	assign frame_accept = frame_end && !frame_bad && frame_len >= rtu_pkg::MIN_FRAME_LEN &&
	                      frame_crc == 16'h0000 && frame_station == station_address;

	assign frame_bus.we    = ctl_idle && rx_done && !rx_err &&
	                         frame_len < 6'(rtu_pkg::FRAME_DEPTH);
	assign frame_bus.waddr = frame_len[4:0];
	assign frame_bus.wdata = rx_data;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gap_cnt       <= 20'h00000;
			frame_len     <= 6'h00;
			frame_bad     <= 1'b0;
			frame_crc     <= rtu_pkg::CRC_INIT;
			frame_station <= 8'h00;
		end else begin
			if (rx_busy) begin
				gap_cnt <= 20'h00000;
			end else if (gap_cnt < gap_end) begin
				gap_cnt <= gap_cnt + 20'h1;
			end
			if (frame_end || !ctl_idle) begin
				frame_len <= 6'h00;
				frame_bad <= 1'b0;
				frame_crc <= rtu_pkg::CRC_INIT;
			end else begin
				if (rx_start && frame_len != 6'h00 && gap_cnt > gap_break) begin
					frame_bad <= 1'b1;
				end
				if (rx_done && (rx_err || frame_len == 6'(rtu_pkg::FRAME_DEPTH))) begin
					frame_bad <= 1'b1;
				end else if (rx_done) begin
					frame_len <= frame_len + 6'h01;
					frame_crc <= rtu_pkg::crc_step(frame_crc, rx_data);
					if (frame_len == 6'h00) begin
						frame_station <= rx_data;
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Request decoding.
	// ---------------------------------------------------------------
	logic [5:0]  ptr;
	logic [5:0]  rd_idx;
	logic        rd_ok;
	logic [5:0]  req_len;
	logic [7:0]  fn;
	logic [15:0] start;
	logic [15:0] qty;
	logic [7:0]  bcnt;
	logic [15:0] n;
	logic [15:0] idx;
	logic        fn_ok;
	logic        addr_ok;
	logic        shape_ok;
	logic [5:0]  dstart;
	logic [5:0]  dlast;
	logic        lo_phase;
	logic [7:0]  hi_byte;
	logic [3:0]  word;
	logic        commit;
	logic        value_bad;
	logic [15:0] value;
	logic [15:0] limit;
	logic        bad_now;
	logic        sweep_end;

	assign fn_ok    = fn == rtu_pkg::FN_READ || fn == rtu_pkg::FN_WRITE_ONE ||
	                  fn == rtu_pkg::FN_WRITE_MANY;
	assign n        = (fn == rtu_pkg::FN_WRITE_ONE) ? 16'h0001 : qty;
	assign idx      = start - rtu_pkg::REG_BASE;
	assign addr_ok  = start >= rtu_pkg::REG_BASE && n <= rtu_pkg::REG_COUNT &&
	                  idx <= rtu_pkg::REG_COUNT - n &&
	                  (fn == rtu_pkg::FN_READ || idx >= rtu_pkg::REG_FIRST_WRITABLE);
	assign shape_ok = n != 16'h0000 && ((fn != rtu_pkg::FN_WRITE_MANY) ?
	                  req_len == rtu_pkg::FIXED_FRAME_LEN :
	                  (bcnt == {n[6:0], 1'b0} && {2'h0, req_len} == rtu_pkg::MULTI_OVERHEAD + bcnt));
	assign dstart   = (fn == rtu_pkg::FN_WRITE_ONE) ? rtu_pkg::POS_DATA_SINGLE :
	                  rtu_pkg::POS_DATA_MULTI;
	assign dlast    = 6'(dstart + {n[4:0], 1'b0} - 6'h01);
	assign lo_phase = rd_idx[0] != dstart[0];
	assign value    = {hi_byte, frame_bus.rdata};
	assign limit    = (idx[3:0] + word == 4'(rtu_pkg::REG_DECIMAL_POINT - rtu_pkg::REG_BASE)) ?
	                  rtu_pkg::LIMIT_DECIMAL_POINT : rtu_pkg::LIMIT_DEFAULT;
	assign bad_now   = rd_ok && lo_phase && value > limit;
	assign sweep_end = rd_ok && rd_idx == dlast;

	assign frame_bus.raddr = ptr[4:0];

	// ---------------------------------------------------------------
	// Response generation.
	// ---------------------------------------------------------------
	logic [5:0]  k;
	logic [5:0]  rlen;
	logic        is_exc;
	logic [7:0]  exc_code;
	logic [15:0] tx_crc;
	logic [7:0]  resp_byte;
	logic [15:0] word_val;
	logic [5:0]  koff;
	logic        tx_go;
	logic        tx_busy;
	logic        tx_done;

	assign koff      = k - 6'h03;
	// commit only after the whole scan passed
	assign param_bus.we    = ctl == C_SWEEP && commit && rd_ok && lo_phase;
	assign param_bus.waddr = idx[3:0] + word;
	assign param_bus.wdata = value;
	assign param_bus.raddr = idx[3:0] + koff[4:1];
	assign word_val  = (param_bus.raddr == 4'h0) ? temp_measured :
	                   (param_bus.raddr == 4'h1) ? humi_measured : param_bus.rdata;
	assign tx_go     = ctl == C_RESP_SEND;

	always_comb begin
		resp_byte = 8'h00;
		if (k == rlen - 6'h02) begin
			resp_byte = tx_crc[7:0];
		end else if (k == rlen - 6'h01) begin
			resp_byte = tx_crc[15:8];
		end else begin
			case (k)
				6'h00:   resp_byte = station_address;
				6'h01:   resp_byte = is_exc ? (fn | rtu_pkg::EXC_FLAG) : fn;
				6'h02:   resp_byte = is_exc ? exc_code :
				                     (fn == rtu_pkg::FN_READ) ? {n[6:0], 1'b0} : start[15:8];
				6'h03:   resp_byte = (fn == rtu_pkg::FN_READ) ? word_val[15:8] : start[7:0];
				6'h04:   resp_byte = (fn == rtu_pkg::FN_READ) ? word_val[7:0] : qty[15:8];
				6'h05:   resp_byte = (fn == rtu_pkg::FN_READ) ? word_val[15:8] : qty[7:0];
				default: resp_byte = koff[0] ? word_val[7:0] : word_val[15:8];
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl <= C_IDLE;
			ptr <= 6'h00;
			rd_idx <= 6'h00;
			rd_ok <= 1'b0;
			req_len <= 6'h00;
			fn <= 8'h00;
			start <= 16'h0000;
			qty <= 16'h0000;
			bcnt <= 8'h00;
			hi_byte <= 8'h00;
			word <= 4'h0;
			commit <= 1'b0;
			value_bad <= 1'b0;
			k <= 6'h00;
			rlen <= 6'h00;
			is_exc <= 1'b0;
			exc_code <= 8'h00;
			tx_crc <= rtu_pkg::CRC_INIT;
		end else begin
			rd_idx <= ptr;
			rd_ok  <= (ctl == C_FETCH) || (ctl == C_SWEEP);
			case (ctl)
				C_IDLE: begin
					if (frame_accept) begin
						req_len <= frame_len;
						ptr     <= rtu_pkg::POS_FUNCTION;
						ctl     <= C_FETCH;
					end
				end
				C_FETCH: begin
					ptr <= ptr + 6'h01;
					if (rd_ok) begin
						case (rd_idx)
							rtu_pkg::POS_FUNCTION: fn <= frame_bus.rdata;
							rtu_pkg::POS_START_HI: start[15:8] <= frame_bus.rdata;
							rtu_pkg::POS_START_LO: start[7:0] <= frame_bus.rdata;
							rtu_pkg::POS_QTY_HI:   qty[15:8] <= frame_bus.rdata;
							rtu_pkg::POS_QTY_LO:   qty[7:0] <= frame_bus.rdata;
							default: begin
								bcnt <= frame_bus.rdata;
								ctl  <= C_DECIDE;
							end
						endcase
					end
				end
				C_DECIDE: begin
					k        <= 6'h00;
					tx_crc   <= rtu_pkg::CRC_INIT;
					is_exc   <= 1'b1;
					rlen     <= rtu_pkg::EXC_REPLY_LEN;
					ctl      <= C_RESP_LOAD;
					if (!fn_ok) begin
						exc_code <= rtu_pkg::EXC_FUNCTION;
					end else if (!addr_ok) begin
						exc_code <= rtu_pkg::EXC_ADDRESS;
					end else if (!shape_ok) begin
						exc_code <= rtu_pkg::EXC_VALUE;
					end else if (fn == rtu_pkg::FN_READ) begin
						is_exc <= 1'b0;
						rlen   <= rtu_pkg::READ_REPLY_EXTRA + {n[4:0], 1'b0};
					end else begin
						ptr       <= dstart;
						word      <= 4'h0;
						commit    <= 1'b0;
						value_bad <= 1'b0;
						ctl       <= C_SWEEP;
					end
				end
				C_SWEEP: begin
					ptr <= ptr + 6'h01;
					if (rd_ok && !lo_phase) begin
						hi_byte <= frame_bus.rdata;
					end
					if (rd_ok && lo_phase) begin
						word <= word + 4'h1;
					end
					if (bad_now) begin
						value_bad <= 1'b1;
					end
					if (sweep_end && commit) begin
						is_exc <= 1'b0;
						rlen   <= rtu_pkg::WRITE_REPLY_LEN;
						ctl    <= C_RESP_LOAD;
					end else if (sweep_end && (value_bad || bad_now)) begin
						exc_code <= rtu_pkg::EXC_VALUE;
						ctl      <= C_RESP_LOAD;
					end else if (sweep_end) begin
						ctl <= C_REWIND;
					end
				end
				C_REWIND: begin
					ptr    <= dstart;
					word   <= 4'h0;
					commit <= 1'b1;
					ctl    <= C_SWEEP;
				end
				C_RESP_LOAD: ctl <= C_RESP_SEND;
				C_RESP_SEND: begin
					if (k < rlen - 6'h02) begin
						tx_crc <= rtu_pkg::crc_step(tx_crc, resp_byte);
					end
					ctl <= C_RESP_WAIT;
				end
				C_RESP_WAIT: begin
					if (tx_done && k == rlen - 6'h01) begin
						ctl <= C_IDLE;
					end else if (tx_done) begin
						k   <= k + 6'h01;
						ctl <= C_RESP_LOAD;
					end
				end
				default: ctl <= C_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Transmitter and parameter store.
	// ---------------------------------------------------------------
	logic [10:0] tx_shift;
	logic [3:0]  tx_left;
	logic [12:0] tx_cnt;

	assign tx_line = tx_shift[0];

	// driver held only while a character is sent
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_shift  <= 11'h7FF;
			tx_left   <= 4'h0;
			tx_cnt    <= 13'h0000;
			tx_busy   <= 1'b0;
			tx_done   <= 1'b0;
			tx_enable <= 1'b0;
		end else begin
			tx_done   <= 1'b0;
			tx_enable <= tx_busy || tx_go;
			if (tx_go) begin
				tx_busy  <= 1'b1;
				tx_shift <= par_en ? {1'b1, parity_bit(resp_byte, parity_select), resp_byte, 1'b0} :
				            {2'b11, resp_byte, 1'b0};
				tx_left  <= char_bits;
				tx_cnt   <= bit_cycles - 13'h0001;
			end else if (tx_busy && tx_cnt != 13'h0000) begin
				tx_cnt <= tx_cnt - 13'h0001;
			end else if (tx_busy) begin
				tx_shift <= {1'b1, tx_shift[10:1]};
				tx_left  <= tx_left - 4'h1;
				tx_cnt   <= bit_cycles - 13'h0001;
				if (tx_left == 4'h1) begin
					tx_busy <= 1'b0;
					tx_done <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			temperature_setpoint <= rtu_pkg::PARAM_RESET;
		end else if (param_bus.we && param_bus.waddr ==
		             4'(rtu_pkg::REG_TEMP_SETPOINT - rtu_pkg::REG_BASE)) begin
			temperature_setpoint <= param_bus.wdata;
		end
	end

	rtu_ram #(
		.WIDTH       (8),
		.AW          (rtu_pkg::FRAME_AW),
		.DEPTH       (rtu_pkg::FRAME_DEPTH),
		.RESET_VALUE (8'h00)
	) frame_ram (
		.clk    (clk),
		.arst_n (arst_n),
		.port   (frame_bus.store)
	);

	rtu_ram #(
		.WIDTH       (16),
		.AW          (rtu_pkg::PARAM_AW),
		.DEPTH       (rtu_pkg::PARAM_DEPTH),
		.RESET_VALUE (rtu_pkg::PARAM_RESET)
	) param_ram (
		.clk    (clk),
		.arst_n (arst_n),
		.port   (param_bus.store)
	);
endmodule
`default_nettype wire

// [verification/rtu_register_slave_chk.sv]
// Port checks of the register slave.
`timescale 1ns/1ps
`default_nettype none
module rtu_register_slave_chk #(
	parameter int BC = 8
) (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        rx_line,
	input wire logic        tx_line,
	input wire logic        tx_enable,
	input wire logic [7:0]  station_address,
	input wire logic [1:0]  baud_select,
	input wire logic [1:0]  parity_select,
	input wire logic [15:0] temp_measured,
	input wire logic [15:0] humi_measured,
	input wire logic [15:0] temperature_setpoint
);
	localparam int GAP = BC * 35;
	logic [15:0] quiet;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			quiet <= 16'h0000;
		else if (!rx_line)
			quiet <= 16'h0000;
		else if (quiet != 16'hFFFF)
			quiet <= quiet + 16'h0001;
	end
	sequence s_start;
		!tx_line [*8];
	endsequence
	sequence s_driven;
		tx_enable [*8];
	endsequence
	property p_start_len; $fell(tx_line) |-> s_start; endproperty
	property p_en_start; $fell(tx_line) |=> s_driven; endproperty
	property p_low_driven; !tx_line && !$fell(tx_line) |-> tx_enable; endproperty
	property p_release; $fell(tx_enable) |-> tx_line && $past(tx_line); endproperty
	property p_rose_en; $rose(tx_enable) |-> !tx_line && $past(tx_line); endproperty
	property p_rx_quiet; $rose(tx_enable) |-> quiet > GAP; endproperty
	property p_sp_quiet; $changed(temperature_setpoint) |-> quiet > GAP; endproperty
	property p_sp_limit; temperature_setpoint <= 16'h03E8; endproperty
	a_start_len: assert property (p_start_len) else $error("start bit short");
	a_en_start: assert property (p_en_start) else $error("driver off in char");
	a_low_driven: assert property (p_low_driven) else $error("low undriven");
	a_release: assert property (p_release) else $error("release not idle");
	a_rose_en: assert property (p_rose_en) else $error("enable w/o start");
	a_rx_quiet: assert property (p_rx_quiet) else $error("reply too early");
	a_sp_quiet: assert property (p_sp_quiet) else $error("setpoint early");
	a_sp_limit: assert property (p_sp_limit) else $error("setpoint range");
endmodule
bind rtu_register_slave rtu_register_slave_chk #(.BC(BIT_CYCLES_9600)) chk (
	.clk, .arst_n, .rx_line, .tx_line, .tx_enable, .station_address, .baud_select,
	.parity_select, .temp_measured, .humi_measured, .temperature_setpoint
);
`default_nettype wire

// [verification/rtu_host_model.sv]
// Bus host model that sends request bytes and collects reply bytes.
`timescale 1ns/1ps
`default_nettype none
module rtu_host_model (
	input  wire logic       clk,
	input  wire logic       tx_line,
	input  wire logic [1:0] par,
	input  wire logic [4:0] bit_len,
	output logic            rx_line
);
	logic [7:0] rq[$];
	int         stop_err;
	initial begin
		rx_line = 1'b1;
		stop_err = 0;
	end
	task automatic send(input logic [7:0] b);
		logic [10:0] w;
		w = {1'b1, par == 2'h0 ? 1'b1 : (^b ^ (par == 2'h1)), b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rx_line <= w[i];
			repeat (bit_len) @(posedge clk);
		end
	endtask
	always begin : rx_proc
		logic [7:0] d;
		@(negedge tx_line);
		repeat (bit_len / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_len) @(posedge clk);
			d[i] = tx_line;
		end
		if (par != 2'h0) begin
			repeat (bit_len) @(posedge clk);
			if (tx_line !== (^d ^ (par == 2'h1)))
				stop_err++;
		end
		repeat (bit_len) @(posedge clk);
		if (tx_line !== 1'b1)
			stop_err++;
		rq.push_back(d);
	end
endmodule
`default_nettype wire

// [verification/tb_rtu_register_slave.sv]
// Self-checking bench for the register slave.
`timescale 1ns/1ps
`default_nettype none
module tb_rtu_register_slave;
	typedef struct {int nq; logic [87:0] rq; int nr; logic [55:0] rs;} row_t;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        rx_line;
	logic        tx_line;
	logic        tx_enable;
	logic [1:0]  parity_select = 2'h0;
	logic [1:0]  baud_select = 2'h1;
	logic [15:0] temperature_setpoint;
	logic [4:0]  bit_len = 5'h08;
	logic [7:0]  station_address = 8'h01;
	logic [15:0] temp_measured = 16'h0123;
	logic [15:0] humi_measured = 16'h0456;
	int          err_count = 0;
	int          n_compared = 0;
	row_t        rows[13] = '{
		'{6, 88'h010320030001, 5, 56'h0103020000},
		'{6, 88'h0106200301F4, 6, 56'h0106200301F4},
		'{6, 88'h010320030001, 5, 56'h01030201F4},
		'{9, 88'h0110200400010201F4, 6, 56'h011020040001},
		'{6, 88'h010320000002, 7, 56'h01030401230456},
		'{6, 88'h010420000001, 3, 56'h018401},
		'{6, 88'h0103201E0001, 3, 56'h018302},
		'{6, 88'h0106200303E9, 3, 56'h018603},
		'{6, 88'h020320030001, 0, 56'h00},
		'{9, 88'h011020010001020005, 3, 56'h019002},
		'{6, 88'h010320080002, 3, 56'h018302},
		'{6, 88'h010320030000, 3, 56'h018303},
		'{6, 88'h010320080001, 5, 56'h0103020000}
	};
	always #25 clk = ~clk;
	rtu_register_slave #(
		.BIT_CYCLES_4800  (16),
		.BIT_CYCLES_9600  (8),
		.BIT_CYCLES_19200 (12)
	) uut (
		.clk                  (clk),
		.arst_n               (arst_n),
		.rx_line              (rx_line),
		.tx_line              (tx_line),
		.tx_enable            (tx_enable),
		.station_address      (station_address),
		.baud_select          (baud_select),
		.parity_select        (parity_select),
		.temp_measured        (temp_measured),
		.humi_measured        (humi_measured),
		.temperature_setpoint (temperature_setpoint)
	);
	rtu_host_model h (.clk(clk), .tx_line(tx_line), .par(parity_select), .bit_len(bit_len),
		.rx_line(rx_line));
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	task automatic fail(input string m);
		$display("[FAIL] %0t %s", $time, m);
		err_count++;
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic run(input row_t r, input int brk, input logic bad);
		logic [7:0]  q[$];
		logic [7:0]  e[$];
		logic [15:0] c;
		int          idle;
		if (bad || brk >= 0)
			r.nr = 0;
		for (int i = 0; i < r.nq; i++)
			q.push_back(r.rq[8 * (r.nq - 1 - i) +: 8]);
		for (int i = 0; i < r.nr; i++)
			e.push_back(r.rs[8 * (r.nr - 1 - i) +: 8]);
		c = crc16(q) ^ {15'h0000, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		c = crc16(e);
		if (r.nr > 0) begin
			e.push_back(c[7:0]);
			e.push_back(c[15:8]);
		end
		h.rq.delete();
		@(posedge clk);
		foreach (q[i]) begin
			if (i == brk)
				repeat (200) @(posedge clk);
			h.send(q[i]);
		end
		idle = 0;
		while (idle < 800) begin
			@(posedge clk);
			idle = (tx_enable === 1'b0) ? idle + 1 : 0;
		end
		n_compared++;
		if (h.rq.size() != e.size())
			fail("reply length");
		else
			foreach (e[i])
				if (h.rq[i] !== e[i])
					fail("reply byte");
		$display("test done: %0d reply bytes", e.size());
	endtask
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (400) @(posedge clk);
		n_compared++;
		if (tx_line !== 1'b1 || tx_enable !== 1'b0 || temperature_setpoint !== 16'h0000)
			fail("reset state");
		foreach (rows[i])
			run(rows[i], -1, 1'b0);
		n_compared++;
		if (temperature_setpoint !== 16'h01F4)
			fail("setpoint port");
		run(rows[2], -1, 1'b1);
		run(rows[2], 3, 1'b0);
		for (int p = 0; p < 3; p++) begin
			parity_select <= p[1:0];
			baud_select <= p[1:0];
			bit_len <= (p == 0) ? 5'h10 : (p == 1) ? 5'h08 : 5'h0C;
			@(posedge clk);
			run(rows[2], -1, 1'b0);
		end
		n_compared++;
		if (h.stop_err != 0)
			fail("stop bit");
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		n_compared++;
		if (temperature_setpoint !== 16'h0000 || tx_enable !== 1'b0 || tx_line !== 1'b1)
			fail("setpoint after reset");
		run(rows[0], -1, 1'b0);
		finish_test();
	end
	initial begin
		repeat (90000) @(posedge clk);
		fail("timeout");
		finish_test();
	end
endmodule
`default_nettype wire
